// file: inc/quad_decoder_pkg.sv
// Contract
// - Sample phases at configured sample period
// - Decode each pair against previous pair
// - Forward step gives +1, still gives 0
// - Reverse step gives -1, decrements accumulator
// - Both phases change: value 2, count it
// - LED on lead time before, off after
// - LED active level follows polarity setting
// - Disconnected LED select releases the pin
// - Filter samples 1 MHz, passes agreed level
// - Long levels pass, short levels suppressed
// - LED stays on while debouncing enabled
// - Debounce adds exactly one period lag
// - Overflowing sample discarded, overflow event raised
// - Both read-clear snapshots and clears both
// - Motion read-clear touches motion accumulator only
// - Double read-clear touches double counter only
// - Report period evaluates, raises ready events
// - Shortcuts fire read-clear tasks on double-ready
// - Sample-ready event on every new sample
package quad_decoder_pkg;
  // Clock and the 1 MHz filter and timing tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 7;
  // Sample period in microseconds is base shifted by the setting
  localparam int SAMPLE_BASE_US = 128;
  localparam int SAMPLE_CFG_MAX = 10;
  localparam int SAMPLE_CFG_W = 4;
  localparam int PERIOD_W = 18;
  // Report period in samples is base shifted by the setting
  localparam int REPORT_BASE = 10;
  localparam int REPORT_CFG_MAX = 8;
  localparam int REPORT_CFG_W = 4;
  localparam int REPORT_W = 12;
  // Lead time in microseconds
  localparam int LEAD_W = 9;
  // Default accumulator widths
  localparam int MOTION_W = 16;
  localparam int DOUBLE_W = 4;
  // Sample value encodings
  localparam int SAMPLE_W = 3;
  localparam logic [2:0] SAMPLE_ZERO = 3'h0;
  localparam logic [2:0] SAMPLE_POS = 3'h1;
  localparam logic [2:0] SAMPLE_NEG = 3'h7;
  localparam logic [2:0] SAMPLE_DBL = 3'h2;
  // Phase pair with both bits changed
  localparam logic [1:0] BOTH_CHANGED = 2'h3;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  // Decoder run state
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN = 2'h2
  } run_state_t;
endpackage

// file: hw/phase_filter.sv
`timescale 1ns/100ps
module phase_filter (
  input wire logic clk_i, // System clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic level_i, // Synchronised phase level
  input wire logic tick_i, // 1 MHz sampling strobe
  input wire logic period_end_i, // Last tick of a sample period
  input wire logic restart_i, // Decoder start
  output logic level_o // Filtered phase level
);
  logic last_r;
  logic diff_r;
  logic level_r;
  logic changed;

  // Level moved since the previous 1 MHz sample
  assign changed = level_i ^ last_r;
  // A period that agreed hands its level on at once, so the added lag is one period
  assign level_o = (tick_i && period_end_i && !restart_i && !(diff_r | changed)) ?
                   level_i : level_r;

  // Pass a level only when every sample of the period agreed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_r <= 1'b0;
      diff_r <= 1'b0;
      level_r <= 1'b0;
    end else if (restart_i) begin
      last_r <= level_i;
      diff_r <= 1'b0;
      level_r <= level_i;
    end else if (tick_i) begin
      last_r <= level_i;
      if (period_end_i) begin
        if (!(diff_r | changed)) begin
          level_r <= level_i;
        end
        diff_r <= 1'b0;
      end else begin
        diff_r <= diff_r | changed;
      end
    end
  end

  // A period with any disagreement leaves the output unchanged
  a_filter_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tick_i && period_end_i && !restart_i && (diff_r || changed)
    |=> $stable(level_o)) else $error("filter passed a disagreeing period");
endmodule

// file: hw/quad_decoder.sv
`timescale 1ns/100ps
module quad_decoder
  import quad_decoder_pkg::*;
#(
  parameter int MOTION_WIDTH = quad_decoder_pkg::MOTION_W,
  parameter int DOUBLE_WIDTH = quad_decoder_pkg::DOUBLE_W,
  parameter int TICK_LEN = quad_decoder_pkg::TICK_CYCLES
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic phase_a_i, // Encoder phase A
  input wire logic phase_b_i, // Encoder phase B
  input wire logic enable_i, // Peripheral enable
  input wire logic start_task_i, // Start pulse
  input wire logic stop_task_i, // Stop pulse
  input wire logic read_clear_both_task_i, // Snapshot and clear both
  input wire logic read_clear_motion_task_i, // Snapshot and clear motion
  input wire logic read_clear_double_task_i, // Snapshot and clear doubles
  input wire logic [quad_decoder_pkg::SAMPLE_CFG_W-1:0] sample_period_cfg_i, // Period select
  input wire logic [quad_decoder_pkg::REPORT_CFG_W-1:0] report_period_cfg_i, // Report select
  input wire logic [quad_decoder_pkg::LEAD_W-1:0] led_lead_time_cfg_i, // Lead in us
  input wire logic led_polarity_cfg_i, // 1 gives active-high LED
  input wire logic debounce_enable_cfg_i, // Filter enable
  input wire logic led_pin_select_i, // 1 when the LED pin is connected
  input wire logic double_ready_to_motion_clear_short_i, // Shortcut enable
  input wire logic double_ready_to_double_clear_short_i, // Shortcut enable
  output logic running_o, // Decoder is sampling
  output logic [quad_decoder_pkg::SAMPLE_W-1:0] sample_o, // Last decoded sample
  output logic [MOTION_WIDTH-1:0] motion_accumulator_o, // Signed motion sum
  output logic [DOUBLE_WIDTH-1:0] double_transition_counter_o, // Double count
  output logic [MOTION_WIDTH-1:0] motion_snapshot_o, // Motion snapshot
  output logic [DOUBLE_WIDTH-1:0] double_snapshot_o, // Double snapshot
  output logic sample_ready_event_o, // Pulse per new sample
  output logic report_ready_event_o, // Pulse, nonzero report
  output logic double_ready_event_o, // Pulse, doubles seen
  output logic accumulator_overflow_event_o, // Pulse, sample discarded
  output logic stopped_event_o, // Pulse after stop
  output logic led_o, // LED pin level
  output logic led_oe_o // LED pin driven
);
  import quad_decoder_pkg::*;

  // Refuse widths the logic cannot serve
  if (MOTION_WIDTH < 2 || DOUBLE_WIDTH < 1 || LEAD_W > PERIOD_W ||
      TICK_LEN < 1 || TICK_LEN > 2 ** TICK_CNT_W) begin : g_bad_param
    $error("quad_decoder: unsupported width parameter");
  end

  localparam logic [MOTION_WIDTH-1:0] MOTION_MAX = {1'b0, {(MOTION_WIDTH-1){1'b1}}};
  localparam logic [MOTION_WIDTH-1:0] MOTION_MIN = {1'b1, {(MOTION_WIDTH-1){1'b0}}};
  localparam logic [DOUBLE_WIDTH-1:0] DOUBLE_MAX = {DOUBLE_WIDTH{1'b1}};

  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt;
  logic [1:0] cur;
  logic [1:0] prev_r;
  logic [1:0] xr;
  run_state_t state_r;
  logic running;
  logic start_go;
  logic [TICK_CNT_W-1:0] pre_r;
  logic tick;
  logic strobe;
  logic [PERIOD_W-1:0] remain_r;
  logic [PERIOD_W-1:0] period_len;
  logic [SAMPLE_CFG_W-1:0] sp_cfg;
  logic [REPORT_CFG_W-1:0] rp_cfg;
  logic [REPORT_W-1:0] report_len;
  logic [REPORT_W-1:0] rpt_r;
  logic step;
  logic pos;
  logic inc;
  logic dec;
  logic dbl;
  logic clear_m;
  logic clear_d;
  logic short_m_r;
  logic short_d_r;
  logic [MOTION_WIDTH-1:0] acc_r;
  logic [MOTION_WIDTH-1:0] acc_base;
  logic [MOTION_WIDTH-1:0] acc_nxt;
  logic [DOUBLE_WIDTH-1:0] dbl_r;
  logic [DOUBLE_WIDTH-1:0] dbl_base;
  logic [DOUBLE_WIDTH-1:0] dbl_nxt;
  logic acc_ovf;
  logic dbl_ovf;
  logic report_due;
  logic dbl_ready_nxt;
  logic led_on;
  logic led_r;
  logic led_oe_r;

  // Two-stage synchroniser for the asynchronous phases
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= PHASE_RESET;
      sync2_r <= PHASE_RESET;
    end else begin
      sync1_r <= {phase_a_i, phase_b_i};
      sync2_r <= sync1_r;
    end
  end

  // One debounce filter per phase
  for (genvar i = 0; i < 2; i++) begin : g_filter
    phase_filter u_phase_filter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .level_i(sync2_r[i]),
      .tick_i(tick),
      .period_end_i(strobe),
      .restart_i(start_go),
      .level_o(filt[i])
    );
  end

  // Filtered phases lag one full period behind the raw ones
  assign cur = debounce_enable_cfg_i ? filt : sync2_r;

  // Start and stop control
  assign running = (state_r == ST_RUN);
  assign start_go = start_task_i & enable_i & ~stop_task_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      stopped_event_o <= 1'b0;
    end else begin
      stopped_event_o <= stop_task_i & enable_i;
      case (state_r)
        ST_IDLE: begin
          if (start_go) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_task_i || !enable_i) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign running_o = running;

  // Clamp settings to the supported range
  assign sp_cfg = (sample_period_cfg_i > SAMPLE_CFG_W'(SAMPLE_CFG_MAX)) ?
                  SAMPLE_CFG_W'(SAMPLE_CFG_MAX) : sample_period_cfg_i;
  assign rp_cfg = (report_period_cfg_i > REPORT_CFG_W'(REPORT_CFG_MAX)) ?
                  REPORT_CFG_W'(REPORT_CFG_MAX) : report_period_cfg_i;
  assign period_len = PERIOD_W'(SAMPLE_BASE_US) << sp_cfg;
  assign report_len = REPORT_W'(REPORT_BASE) << rp_cfg;

  // 1 MHz tick and sample-period countdown
  assign tick = running && (pre_r == TICK_CNT_W'(TICK_LEN - 1));
  assign strobe = tick && (remain_r == '0);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_r <= '0;
      remain_r <= '0;
    end else if (start_go) begin
      pre_r <= '0;
      remain_r <= period_len - PERIOD_W'(1);
    end else if (running) begin
      pre_r <= tick ? '0 : pre_r + TICK_CNT_W'(1);
      if (strobe) begin
        remain_r <= period_len - PERIOD_W'(1);
      end else if (tick) begin
        remain_r <= remain_r - PERIOD_W'(1);
      end
    end
  end

  // Compare the new phase pair with the previous one
  assign xr = prev_r ^ cur;
  assign step = (xr != 2'h0) && (xr != BOTH_CHANGED);
  assign pos = prev_r[1] ^ cur[0];
  assign inc = strobe & step & pos;
  assign dec = strobe & step & ~pos;
  assign dbl = strobe && (xr == BOTH_CHANGED);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_r <= PHASE_RESET;
    end else if (start_go) begin
      prev_r <= sync2_r;
    end else if (strobe) begin
      prev_r <= cur;
    end
  end

  // Decoded sample value and its ready pulse
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_o <= SAMPLE_ZERO;
      sample_ready_event_o <= 1'b0;
    end else begin
      sample_ready_event_o <= strobe;
      if (inc) begin
        sample_o <= SAMPLE_POS;
      end else if (dec) begin
        sample_o <= SAMPLE_NEG;
      end else if (dbl) begin
        sample_o <= SAMPLE_DBL;
      end else if (strobe) begin
        sample_o <= SAMPLE_ZERO;
      end
    end
  end

  // A clear in the same cycle as a sample keeps that sample
  assign clear_m = read_clear_both_task_i | read_clear_motion_task_i | short_m_r;
  assign clear_d = read_clear_both_task_i | read_clear_double_task_i | short_d_r;
  assign acc_base = clear_m ? '0 : acc_r;
  assign dbl_base = clear_d ? '0 : dbl_r;
  assign acc_ovf = (inc && acc_base == MOTION_MAX) || (dec && acc_base == MOTION_MIN);
  assign dbl_ovf = dbl && (dbl_base == DOUBLE_MAX);

  // Next accumulator values; overflowing samples are dropped
  always_comb begin
    acc_nxt = acc_base;
    dbl_nxt = dbl_base;
    if (inc && !acc_ovf) begin
      acc_nxt = acc_base + MOTION_WIDTH'(1);
    end else if (dec && !acc_ovf) begin
      acc_nxt = acc_base - MOTION_WIDTH'(1);
    end
    if (dbl && !dbl_ovf) begin
      dbl_nxt = dbl_base + DOUBLE_WIDTH'(1);
    end
  end

  // Accumulators and overflow pulse
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_r <= '0;
      dbl_r <= '0;
      accumulator_overflow_event_o <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      dbl_r <= dbl_nxt;
      accumulator_overflow_event_o <= acc_ovf | dbl_ovf;
    end
  end
  assign motion_accumulator_o = acc_r;
  assign double_transition_counter_o = dbl_r;

  // Snapshots taken by the read-clear tasks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      motion_snapshot_o <= '0;
      double_snapshot_o <= '0;
    end else begin
      if (clear_m) begin
        motion_snapshot_o <= acc_r;
      end
      if (clear_d) begin
        double_snapshot_o <= dbl_r;
      end
    end
  end

  // Report period sample counter and evaluation
  assign report_due = strobe && (rpt_r == report_len - REPORT_W'(1));
  assign dbl_ready_nxt = report_due && (dbl_nxt != '0);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rpt_r <= '0;
      report_ready_event_o <= 1'b0;
      double_ready_event_o <= 1'b0;
    end else begin
      report_ready_event_o <= report_due && (acc_nxt != '0);
      double_ready_event_o <= dbl_ready_nxt;
      if (start_go || report_due) begin
        rpt_r <= '0;
      end else if (strobe) begin
        rpt_r <= rpt_r + REPORT_W'(1);
      end
    end
  end

  // Shortcuts from double-ready to the read-clear tasks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      short_m_r <= 1'b0;
      short_d_r <= 1'b0;
    end else begin
      short_m_r <= dbl_ready_nxt & double_ready_to_motion_clear_short_i;
      short_d_r <= dbl_ready_nxt & double_ready_to_double_clear_short_i;
    end
  end

  // LED on during the lead time, or always while filtering
  assign led_on = running &&
                  (debounce_enable_cfg_i || remain_r < PERIOD_W'(led_lead_time_cfg_i));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      led_r <= 1'b0;
      led_oe_r <= 1'b0;
    end else begin
      led_oe_r <= enable_i & led_pin_select_i;
      if (enable_i && led_pin_select_i) begin
        led_r <= led_on ? led_polarity_cfg_i : ~led_polarity_cfg_i;
      end else begin
        led_r <= 1'b0;
      end
    end
  end
  assign led_o = led_r;
  assign led_oe_o = led_oe_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_sample_rate: assert property (strobe |=> !strobe [*8])
    else $error("sample strobes closer than a period");
  a_pos_step: assert property (inc && !acc_ovf && !clear_m |=>
    acc_r == $past(acc_r) + MOTION_WIDTH'(1) && sample_o == SAMPLE_POS)
    else $error("forward step not counted");
  a_neg_step: assert property (dec && !acc_ovf && !clear_m |=>
    acc_r == $past(acc_r) - MOTION_WIDTH'(1) && sample_o == SAMPLE_NEG)
    else $error("reverse step not counted");
  a_neg_keeps_dbl: assert property (dec && !clear_d |=> $stable(dbl_r))
    else $error("reverse step moved the double counter");
  a_double_step: assert property (dbl && !dbl_ovf && !clear_m && !clear_d |=>
    $stable(acc_r) && dbl_r == $past(dbl_r) + DOUBLE_WIDTH'(1))
    else $error("double transition mishandled");
  a_still_pair: assert property (strobe && !step && !dbl && !clear_m && !clear_d |=>
    $stable(acc_r) && $stable(dbl_r) && sample_o == SAMPLE_ZERO)
    else $error("unchanged pair altered state");
  a_led_off_after: assert property (strobe && !debounce_enable_cfg_i && enable_i &&
    led_pin_select_i && PERIOD_W'(led_lead_time_cfg_i) < period_len && !stop_task_i
    ##1 !stop_task_i && enable_i |=> led_o == !led_polarity_cfg_i)
    else $error("LED not off after sampling");
  a_led_debounce: assert property (running && debounce_enable_cfg_i && enable_i &&
    led_pin_select_i |=> led_o == $past(led_polarity_cfg_i))
    else $error("LED not held on while filtering");
  a_led_release: assert property (!led_pin_select_i |=> !led_oe_o && !led_o)
    else $error("LED pin claimed while disconnected");
  a_overflow_drop: assert property (acc_ovf && !clear_m |=>
    accumulator_overflow_event_o && $stable(acc_r))
    else $error("overflowing sample not discarded");
  a_snap_both: assert property (read_clear_both_task_i && !strobe |=>
    motion_snapshot_o == $past(acc_r) && double_snapshot_o == $past(dbl_r) &&
    acc_r == '0 && dbl_r == '0)
    else $error("combined read-clear wrong");
  a_snap_motion: assert property (read_clear_motion_task_i && !read_clear_both_task_i &&
    !read_clear_double_task_i && !short_d_r && !strobe |=>
    acc_r == '0 && $stable(dbl_r) && motion_snapshot_o == $past(acc_r))
    else $error("motion read-clear wrong");
  a_snap_double: assert property (read_clear_double_task_i && !read_clear_both_task_i &&
    !read_clear_motion_task_i && !short_m_r && !strobe |=>
    dbl_r == '0 && $stable(acc_r) && double_snapshot_o == $past(dbl_r))
    else $error("double read-clear wrong");
  a_report_ready: assert property (report_due && acc_nxt != '0 |=> report_ready_event_o)
    else $error("report-ready missing");
  a_short_fire: assert property (dbl_ready_nxt && double_ready_to_double_clear_short_i
    |=> double_ready_event_o ##1 dbl_r == '0 || dbl_r == DOUBLE_WIDTH'(1))
    else $error("double-clear shortcut did not fire");
  a_sample_ready: assert property (strobe |=> sample_ready_event_o)
    else $error("sample-ready missing");
endmodule

// file: tb/encoder_model.sv
`timescale 1ns/100ps
module encoder_model #(
  parameter int SETTLE = 3
) (
  input wire logic clk_i, // System clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic step_i, // Move request pulse
  input wire logic [1:0] dir_i, // 0 hold, 1 forward, 2 reverse, 3 both phases
  output logic phase_a_o, // Phase A level
  output logic phase_b_o // Phase B level
);
  logic [1:0] pair_r;
  logic [1:0] want_r;
  logic [7:0] wait_r;

  // Next shaft position as {A,B} for the requested move
  function automatic logic [1:0] next_pair(input logic [1:0] p, input logic [1:0] d);
    case (d)
      2'h1: next_pair = {p[0], ~p[1]};
      2'h2: next_pair = {~p[0], p[1]};
      2'h3: next_pair = ~p;
      default: next_pair = p;
    endcase
  endfunction

  // Phases move only after the settle time, like a slow wheel
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pair_r <= 2'h0;
      want_r <= 2'h0;
      wait_r <= 8'h00;
    end else if (step_i) begin
      want_r <= next_pair(want_r, dir_i);
      wait_r <= 8'(SETTLE);
    end else if (wait_r != 8'h00) begin
      wait_r <= wait_r - 8'h01;
      if (wait_r == 8'h01) begin
        pair_r <= want_r;
      end
    end
  end

  // Wheel lines are always driven by the encoder
  assign phase_a_o = pair_r[1];
  assign phase_b_o = pair_r[0];
endmodule

// file: tb/quad_decoder_tb_top.sv
`timescale 1ns/100ps
module quad_decoder_tb_top;
  import quad_decoder_pkg::*;
  localparam int MW = 2;
  localparam int DW = 4;
  // Short tick keeps the run brief; every period scales with it
  localparam int TICK = 4;
  localparam int PERIOD = SAMPLE_BASE_US * TICK;
  localparam int LEAD = 20;
  localparam int LIMIT_NS = 64 * PERIOD * CLK_PERIOD_NS;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic enable = 1'h1;
  logic start_task = 1'h0;
  logic stop_task = 1'h0;
  logic clr_both = 1'h0;
  logic clr_motion = 1'h0;
  logic clr_double = 1'h0;
  logic [SAMPLE_CFG_W-1:0] sample_cfg = 4'h0;
  logic [REPORT_CFG_W-1:0] report_cfg = 4'h0;
  logic [LEAD_W-1:0] lead_cfg = 9'h014;
  logic led_pol = 1'h1;
  logic debounce = 1'h0;
  logic led_sel = 1'h1;
  logic short_en = 1'h0;
  logic step = 1'h0;
  logic [1:0] dir = 2'h0;
  logic phase_a, phase_b, running, smp_rdy, rep_rdy, dbl_rdy, ovf, stopped, led, led_oe;
  logic [SAMPLE_W-1:0] sample;
  logic [MW-1:0] acc, msnap;
  logic [DW-1:0] dbl, dsnap;
  logic ovf_seen;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int last_t = 0;
  int per = 0;
  int led_cnt = 0;

  // Clock and cycle count
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  encoder_model u_encoder_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .step_i(step),
    .dir_i(dir), .phase_a_o(phase_a), .phase_b_o(phase_b));

  quad_decoder #(.MOTION_WIDTH(MW), .DOUBLE_WIDTH(DW), .TICK_LEN(TICK)) u_quad_decoder (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .phase_a_i(phase_a), .phase_b_i(phase_b),
    .enable_i(enable), .start_task_i(start_task), .stop_task_i(stop_task),
    .read_clear_both_task_i(clr_both), .read_clear_motion_task_i(clr_motion),
    .read_clear_double_task_i(clr_double), .sample_period_cfg_i(sample_cfg),
    .report_period_cfg_i(report_cfg), .led_lead_time_cfg_i(lead_cfg),
    .led_polarity_cfg_i(led_pol), .debounce_enable_cfg_i(debounce),
    .led_pin_select_i(led_sel), .double_ready_to_motion_clear_short_i(short_en),
    .double_ready_to_double_clear_short_i(short_en), .running_o(running), .sample_o(sample),
    .motion_accumulator_o(acc), .double_transition_counter_o(dbl),
    .motion_snapshot_o(msnap), .double_snapshot_o(dsnap), .sample_ready_event_o(smp_rdy),
    .report_ready_event_o(rep_rdy), .double_ready_event_o(dbl_rdy),
    .accumulator_overflow_event_o(ovf), .stopped_event_o(stopped), .led_o(led),
    .led_oe_o(led_oe));

  // Compare one value and count the outcome
  task chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task finish_test;
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One-cycle task pulse: 0 start, 1 stop, 2 both, 3 motion, 4 double
  task pulse(input int which);
    @(negedge clk_i);
    case (which)
      0: start_task = 1'h1;
      1: stop_task = 1'h1;
      2: clr_both = 1'h1;
      3: clr_motion = 1'h1;
      default: clr_double = 1'h1;
    endcase
    @(negedge clk_i);
    start_task = 1'h0;
    stop_task = 1'h0;
    clr_both = 1'h0;
    clr_motion = 1'h0;
    clr_double = 1'h0;
    @(negedge clk_i);
  endtask

  // Wait for the next decoded sample, watching the LED and overflow meanwhile
  task wait_sample;
    int n;
    n = 0;
    led_cnt = 0;
    ovf_seen = 1'h0;
    do begin
      @(negedge clk_i);
      n++;
      if (led === 1'h1) led_cnt++;
      if (ovf === 1'h1) ovf_seen = 1'h1;
    end while (smp_rdy !== 1'h1 && n < 2 * PERIOD + 500);
    chk("sample ready", 18'(1), 18'(smp_rdy));
    per = cyc - last_t;
    last_t = cyc;
  endtask

  // Move the wheel once, then judge the next sample
  task step_chk(input logic [1:0] d, input logic [2:0] es, input logic [MW-1:0] ea,
                input logic [DW-1:0] ed, input logic eo);
    @(negedge clk_i);
    step = 1'h1;
    dir = d;
    @(negedge clk_i);
    step = 1'h0;
    wait_sample;
    chk("sample", 18'(es), 18'(sample));
    chk("motion", 18'(ea), 18'(acc));
    chk("double", 18'(ed), 18'(dbl));
    chk("overflow", 18'(eo), 18'(ovf_seen));
  endtask

  // Snapshots and accumulators after a read-clear
  task snap_chk(input logic [MW-1:0] ms, input logic [DW-1:0] ds, input logic [MW-1:0] ea,
                input logic [DW-1:0] ed);
    chk("motion snapshot", 18'(ms), 18'(msnap));
    chk("double snapshot", 18'(ds), 18'(dsnap));
    chk("motion", 18'(ea), 18'(acc));
    chk("double", 18'(ed), 18'(dbl));
  endtask

  task sc_reset;
    chk("running", 18'(0), 18'(running));
    chk("sample", 18'(0), 18'(sample));
    snap_chk(2'h0, 4'h0, 2'h0, 4'h0);
  endtask

  task sc_start_led;
    pulse(0);
    chk("running", 18'(1), 18'(running));
    step_chk(2'h1, SAMPLE_POS, 2'h1, 4'h0, 1'h0);
    chk("led lead", 18'(1), 18'(led_cnt >= LEAD * TICK - 2 && led_cnt <= LEAD * TICK + 2));
    @(negedge clk_i);
    chk("led off", 18'(0), 18'(led));
    chk("led driven", 18'(1), 18'(led_oe));
  endtask

  task sc_overflow;
    step_chk(2'h1, SAMPLE_POS, 2'h1, 4'h0, 1'h1);
    chk("period", 18'(PERIOD), 18'(per));
    step_chk(2'h3, SAMPLE_DBL, 2'h1, 4'h1, 1'h0);
  endtask

  task sc_read_clear;
    pulse(3);
    snap_chk(2'h1, 4'h0, 2'h0, 4'h1);
    step_chk(2'h2, SAMPLE_NEG, 2'h3, 4'h1, 1'h0);
    pulse(4);
    snap_chk(2'h1, 4'h1, 2'h3, 4'h0);
    step_chk(2'h3, SAMPLE_DBL, 2'h3, 4'h1, 1'h0);
    pulse(2);
    snap_chk(2'h3, 4'h1, 2'h0, 4'h0);
    step_chk(2'h0, SAMPLE_ZERO, 2'h0, 4'h0, 1'h0);
  endtask

  task sc_debounce;
    @(negedge clk_i);
    stop_task = 1'h1;
    @(negedge clk_i);
    stop_task = 1'h0;
    ovf_seen = stopped;
    @(negedge clk_i);
    chk("stopped", 18'(1), 18'(ovf_seen | stopped));
    chk("running", 18'(0), 18'(running));
    debounce = 1'h1;
    led_pol = 1'h0;
    pulse(0);
    step_chk(2'h1, SAMPLE_ZERO, 2'h0, 4'h0, 1'h0);
    chk("led held on", 18'(0), 18'(led_cnt));
    step_chk(2'h0, SAMPLE_POS, 2'h1, 4'h0, 1'h0);
  endtask

  task sc_release;
    pulse(1);
    led_sel = 1'h0;
    repeat (3) @(negedge clk_i);
    chk("led driven", 18'(0), 18'(led_oe));
  endtask

  // Doubled period, report evaluation and the double-ready shortcuts
  task sc_report;
    sample_cfg = 4'h1;
    debounce = 1'h0;
    short_en = 1'h1;
    pulse(0);
    step_chk(2'h3, SAMPLE_DBL, 2'h1, 4'h1, 1'h0);
    step_chk(2'h0, SAMPLE_ZERO, 2'h1, 4'h1, 1'h0);
    chk("period", 18'(2 * PERIOD), 18'(per));
    repeat (8) step_chk(2'h0, SAMPLE_ZERO, 2'h1, 4'h1, 1'h0);
    chk("report ready", 18'(1), 18'(rep_rdy));
    chk("double ready", 18'(1), 18'(dbl_rdy));
    @(negedge clk_i);
    snap_chk(2'h1, 4'h1, 2'h0, 4'h0);
    repeat (10) step_chk(2'h0, SAMPLE_ZERO, 2'h0, 4'h0, 1'h0);
    chk("report ready", 18'(0), 18'(rep_rdy));
    chk("double ready", 18'(0), 18'(dbl_rdy));
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'h1;
    sc_reset;
    sc_start_led;
    sc_overflow;
    sc_read_clear;
    sc_debounce;
    sc_release;
    sc_report;
    finish_test;
  end

  // Watchdog against a hang
  initial begin
    #(LIMIT_NS);
    n_fail++;
    $display("BAD watchdog expected end seen hang");
    finish_test;
  end
endmodule
